/* core/clk_ctrl_pkg.sv */
`default_nettype none
package clk_ctrl_pkg;
	// ----------------------------------------------------------------
	// Divider and multiplier encodings
	// ----------------------------------------------------------------
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] DIV_MAX = 3'h6;
	localparam int MULT_W = 6;
	// Code k selects a factor of 10 + k/2
	localparam logic [MULT_W-1:0] MULT_CODE_MAX = 6'h28;
	localparam logic [MULT_W-1:0] MULT_CODE_RST = 6'h00;
	localparam int WAIT_W = 16;
	localparam logic [WAIT_W-1:0] WAIT_RST = 16'hffff;
	// ----------------------------------------------------------------
	// Derived clock indices
	// ----------------------------------------------------------------
	localparam int NUM_CLK = 6;
	localparam int CLK_CORE = 0;
	localparam int CLK_FLASH = 1;
	localparam int CLK_FAST = 2;
	localparam int CLK_SLOW = 3;
	localparam int CLK_TIMER = 4;
	localparam int CLK_CONV = 5;
	// ----------------------------------------------------------------
	// Module stop register A
	// ----------------------------------------------------------------
	localparam int MSTP_HI0 = 24;
	localparam int MSTP_HI1 = 27;
	localparam int MSTP_HI2 = 29;
	localparam logic [31:0] MSTP_RST = 32'hffff_ffff;
	// ----------------------------------------------------------------
	// Oscillator-to-PLL state
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PLL_OFF = 2'b00,
		PLL_WAIT = 2'b01,
		PLL_LOCK = 2'b11
	} pll_state_t;
endpackage
`default_nettype wire

/* core/clk_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_tick_gen #(
	parameter int N = clk_ctrl_pkg::NUM_CLK,
	parameter int W = clk_ctrl_pkg::DIV_W
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic run_i,
	input wire logic [N*W-1:0] div_i,
	output logic [N-1:0] tick_o
);
	// ----------------------------------------------------------------
	// Shared prescaler
	// ----------------------------------------------------------------
	// One counter for all outputs keeps every tick phase aligned
	localparam int CW = 1 << W;
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [N-1:0] tick_q;
	wire logic [N-1:0] tick_d;

	always_comb
	begin
		cnt_d = run_i ? cnt_q + CNT_ONE : '0;
	end

	// ----------------------------------------------------------------
	// Per-clock enables
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_tick
			// One driver per bit keeps each enable in its own net
			wire logic [CW-1:0] mask;
			assign mask = (CNT_ONE << div_i[g*W +: W]) - CNT_ONE;
			assign tick_d[g] = run_i && ((cnt_q & mask) == '0);
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_q <= '0;
			tick_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
endmodule
`default_nettype wire

/* core/clock_ratio_and_pll_control.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_ratio_and_pll_control #(
	parameter int DIV_W = clk_ctrl_pkg::DIV_W,
	parameter int MULT_W = clk_ctrl_pkg::MULT_W,
	parameter int WAIT_W = clk_ctrl_pkg::WAIT_W
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic cfg_wr_i,
	input wire logic [DIV_W-1:0] div_core_i,
	input wire logic [DIV_W-1:0] div_flash_i,
	input wire logic [DIV_W-1:0] div_fast_i,
	input wire logic [DIV_W-1:0] div_slow_i,
	input wire logic [DIV_W-1:0] div_timer_i,
	input wire logic [DIV_W-1:0] div_conv_i,
	input wire logic pll_wr_i,
	input wire logic pll_en_i,
	input wire logic [MULT_W-1:0] pll_multiplier_field_i,
	input wire logic [WAIT_W-1:0] pll_wait_i,
	input wire logic src_wr_i,
	input wire logic src_pll_i,
	input wire logic mstp_wr_i,
	input wire logic [31:0] mstp_a_i,
	input wire logic err_clr_i,
	output logic [DIV_W-1:0] div_core_o,
	output logic [DIV_W-1:0] div_flash_o,
	output logic [DIV_W-1:0] div_fast_o,
	output logic [DIV_W-1:0] div_slow_o,
	output logic [DIV_W-1:0] div_timer_o,
	output logic [DIV_W-1:0] div_conv_o,
	output logic [MULT_W-1:0] pll_multiplier_field_o,
	output logic pll_locked_o,
	output logic src_pll_o,
	output logic cfg_err_o,
	output logic all_stop_o,
	output logic core_system_clock_en_o,
	output logic flash_interface_clock_en_o,
	output logic periph_bus_clock_fast_en_o,
	output logic periph_bus_clock_slow_en_o,
	output logic converter_clock_en_o,
	output logic timer_count_en_o,
	output logic timer_bus_en_o
);
	localparam int N = clk_ctrl_pkg::NUM_CLK;

	// ----------------------------------------------------------------
	// Configuration state
	// ----------------------------------------------------------------
	logic [N*DIV_W-1:0] div_q;
	logic [N*DIV_W-1:0] div_d;
	logic [N*DIV_W-1:0] div_req;
	logic [MULT_W-1:0] mult_q;
	logic [MULT_W-1:0] mult_d;
	logic [WAIT_W-1:0] wait_q;
	logic [WAIT_W-1:0] wait_d;
	logic [WAIT_W-1:0] wcnt_q;
	logic [WAIT_W-1:0] wcnt_d;
	clk_ctrl_pkg::pll_state_t pll_q;
	clk_ctrl_pkg::pll_state_t pll_d;
	logic src_q;
	logic src_d;
	logic err_q;
	logic err_d;
	logic [31:0] mstp_q;
	logic [31:0] mstp_d;
	logic stop_q;
	logic stop_d;
	logic locked_q;
	logic locked_d;
	logic div_ok;
	logic mult_ok;
	logic [N-1:0] tick;

	assign div_req = {div_conv_i, div_timer_i, div_slow_i, div_fast_i,
		div_flash_i, div_core_i};

	// ----------------------------------------------------------------
	// Legality check
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [DIV_W-1:0] fa;
		logic [DIV_W-1:0] sl;
		logic [DIV_W-1:0] tm;
		logic [DIV_W-1:0] cv;
		logic [DIV_W:0] slw;
		logic [DIV_W:0] cvw;
		fa = div_fast_i;
		sl = div_slow_i;
		tm = div_timer_i;
		cv = div_conv_i;
		slw = {1'b0, div_slow_i};
		cvw = {1'b0, div_conv_i};
		div_ok = 1'b1;
		// Power-of-two dividers only
		// integer ratios
		for (int i = 0; i < N; i++)
		begin
			if (div_req[i*DIV_W +: DIV_W] > clk_ctrl_pkg::DIV_MAX)
				div_ok = 1'b0;
		end
		if (tm > fa || fa > sl)
			div_ok = 1'b0;
		if (fa - tm > 3'h1)
			div_ok = 1'b0;
		// slow to converter
		// One bit wider so a slow code near the top cannot wrap
		if (!(cvw == slw || cvw == slw + (DIV_W+1)'(1) ||
			cvw == slw + (DIV_W+1)'(2) || cvw + (DIV_W+1)'(1) == slw))
			div_ok = 1'b0;
		mult_ok = pll_multiplier_field_i <= clk_ctrl_pkg::MULT_CODE_MAX;
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		div_d = div_q;
		mult_d = mult_q;
		wait_d = wait_q;
		wcnt_d = wcnt_q;
		pll_d = pll_q;
		src_d = src_q;
		err_d = err_q && !err_clr_i;
		mstp_d = mstp_q;
		if (cfg_wr_i)
		begin
			if (div_ok)
				div_d = div_req;
			else
				err_d = 1'b1;
		end
		// Retuning while the core runs from the PLL would glitch it
		if (pll_wr_i)
		begin
			if (!mult_ok || src_q)
				err_d = 1'b1;
			else
			begin
				mult_d = pll_multiplier_field_i;
				wait_d = pll_wait_i;
				wcnt_d = '0;
				pll_d = pll_en_i ? clk_ctrl_pkg::PLL_WAIT : clk_ctrl_pkg::PLL_OFF;
			end
		end
		else
		begin
			unique case (pll_q)
				clk_ctrl_pkg::PLL_OFF:
					pll_d = clk_ctrl_pkg::PLL_OFF;
				clk_ctrl_pkg::PLL_WAIT:
				begin
					if (wcnt_q >= wait_q)
						pll_d = clk_ctrl_pkg::PLL_LOCK;
					else
						wcnt_d = wcnt_q + WAIT_W'(1);
				end
				clk_ctrl_pkg::PLL_LOCK:
					pll_d = clk_ctrl_pkg::PLL_LOCK;
				default:
					pll_d = clk_ctrl_pkg::PLL_OFF;
			endcase
		end
		if (src_wr_i)
		begin
			if (src_pll_i && pll_q != clk_ctrl_pkg::PLL_LOCK)
				err_d = 1'b1;
			else
				src_d = src_pll_i;
		end
		if (mstp_wr_i)
			mstp_d = mstp_a_i;
		stop_d = mstp_d[clk_ctrl_pkg::MSTP_HI0] &&
			mstp_d[clk_ctrl_pkg::MSTP_HI1] &&
			mstp_d[clk_ctrl_pkg::MSTP_HI2];
		locked_d = pll_d == clk_ctrl_pkg::PLL_LOCK;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			div_q <= '0;
			mult_q <= clk_ctrl_pkg::MULT_CODE_RST;
			wait_q <= clk_ctrl_pkg::WAIT_RST;
			wcnt_q <= '0;
			pll_q <= clk_ctrl_pkg::PLL_OFF;
			src_q <= 1'b0;
			err_q <= 1'b0;
			mstp_q <= clk_ctrl_pkg::MSTP_RST;
			stop_q <= 1'b1;
			locked_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			mult_q <= mult_d;
			wait_q <= wait_d;
			wcnt_q <= wcnt_d;
			pll_q <= pll_d;
			src_q <= src_d;
			err_q <= err_d;
			mstp_q <= mstp_d;
			stop_q <= stop_d;
			locked_q <= locked_d;
		end
	end

	// ----------------------------------------------------------------
	// Clock enables
	// ----------------------------------------------------------------
	// Stopped during all-module stop; enables freeze low, not mid-pulse
	clk_tick_gen #(
		.N(N),
		.W(DIV_W)
	) u_ticks (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.run_i(!stop_q),
		.div_i(div_q),
		.tick_o(tick)
	);

	assign div_core_o = div_q[clk_ctrl_pkg::CLK_CORE*DIV_W +: DIV_W];
	assign div_flash_o = div_q[clk_ctrl_pkg::CLK_FLASH*DIV_W +: DIV_W];
	assign div_fast_o = div_q[clk_ctrl_pkg::CLK_FAST*DIV_W +: DIV_W];
	assign div_slow_o = div_q[clk_ctrl_pkg::CLK_SLOW*DIV_W +: DIV_W];
	assign div_timer_o = div_q[clk_ctrl_pkg::CLK_TIMER*DIV_W +: DIV_W];
	assign div_conv_o = div_q[clk_ctrl_pkg::CLK_CONV*DIV_W +: DIV_W];
	assign pll_multiplier_field_o = mult_q;
	assign pll_locked_o = locked_q;
	assign src_pll_o = src_q;
	assign cfg_err_o = err_q;
	assign all_stop_o = stop_q;
	assign core_system_clock_en_o = tick[clk_ctrl_pkg::CLK_CORE];
	assign flash_interface_clock_en_o = tick[clk_ctrl_pkg::CLK_FLASH];
	assign periph_bus_clock_fast_en_o = tick[clk_ctrl_pkg::CLK_FAST];
	assign periph_bus_clock_slow_en_o = tick[clk_ctrl_pkg::CLK_SLOW];
	assign converter_clock_en_o = tick[clk_ctrl_pkg::CLK_CONV];
	assign timer_count_en_o = tick[clk_ctrl_pkg::CLK_TIMER];
	assign timer_bus_en_o = tick[clk_ctrl_pkg::CLK_FAST];
endmodule
`default_nettype wire

/* dv/clk_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_properties #(
	parameter int DIV_W = 3,
	parameter int MULT_W = 6,
	parameter int WAIT_W = 16
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic cfg_wr_i,
	input wire logic [DIV_W-1:0] div_core_i,
	input wire logic [DIV_W-1:0] div_fast_o,
	input wire logic [DIV_W-1:0] div_slow_o,
	input wire logic [DIV_W-1:0] div_timer_o,
	input wire logic [DIV_W-1:0] div_conv_o,
	input wire logic pll_wr_i,
	input wire logic pll_en_i,
	input wire logic [MULT_W-1:0] pll_multiplier_field_i,
	input wire logic [WAIT_W-1:0] pll_wait_i,
	input wire logic [MULT_W-1:0] pll_multiplier_field_o,
	input wire logic pll_locked_o,
	input wire logic src_wr_i,
	input wire logic src_pll_o,
	input wire logic cfg_err_o,
	input wire logic mstp_wr_i,
	input wire logic [31:0] mstp_a_i,
	input wire logic all_stop_o,
	input wire logic core_system_clock_en_o,
	input wire logic periph_bus_clock_fast_en_o,
	input wire logic timer_bus_en_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Wait count of two: three unlocked cycles after the write, then lock
	sequence lock_s;
		!pll_locked_o [*3] ##1 pll_locked_o;
	endsequence
	sequence pll_go_s;
		pll_wr_i && pll_en_i && pll_wait_i == 16'h0002 && !src_pll_o &&
		pll_multiplier_field_i <= 6'h28;
	endsequence
	bad_code_a: assert property (cfg_wr_i && div_core_i == 3'h7 |=> cfg_err_o)
		else $error("bad code not flagged");
	keep_div_a: assert property (cfg_wr_i && div_core_i == 3'h7 |=> $stable(div_fast_o))
		else $error("refused setting applied");
	timer_ratio_a: assert property (div_timer_o <= div_fast_o && div_fast_o - div_timer_o <= 1)
		else $error("timer ratio broken");
	conv_ratio_a: assert property (div_conv_o + 1 >= div_slow_o && div_conv_o <= div_slow_o + 2)
		else $error("converter ratio broken");
	mult_range_a: assert property (pll_multiplier_field_o <= 6'h28)
		else $error("multiplier out of range");
	src_lock_a: assert property ($rose(src_pll_o) |-> $past(src_wr_i) && $past(pll_locked_o))
		else $error("source switched without lock");
	lock_time_a: assert property (pll_go_s |=> lock_s)
		else $error("lock timing wrong");
	stop_enter_a: assert property (mstp_wr_i && mstp_a_i[24] && mstp_a_i[27] && mstp_a_i[29] |=> all_stop_o)
		else $error("stop not entered");
	stop_exit_a: assert property (mstp_wr_i && !mstp_a_i[27] |=> !all_stop_o)
		else $error("stop entered wrongly");
	stop_gate_a: assert property (all_stop_o && $past(all_stop_o) |-> !core_system_clock_en_o)
		else $error("clock runs while stopped");
	bus_en_a: assert property (timer_bus_en_o == periph_bus_clock_fast_en_o)
		else $error("timer bus clock wrong");
endmodule
bind clock_ratio_and_pll_control clk_ctrl_properties #(
	.DIV_W(DIV_W),
	.MULT_W(MULT_W),
	.WAIT_W(WAIT_W)
) chk (.*);
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk_i, arst_n_i, cfg_wr_i, pll_wr_i, pll_en_i, src_wr_i;
	logic src_pll_i, mstp_wr_i, err_clr_i;
	logic [2:0] div_core_i, div_flash_i, div_fast_i, div_slow_i;
	logic [2:0] div_timer_i, div_conv_i, div_core_o, div_flash_o;
	logic [2:0] div_fast_o, div_slow_o, div_timer_o, div_conv_o;
	logic [5:0] pll_multiplier_field_i, pll_multiplier_field_o;
	logic [15:0] pll_wait_i;
	logic [31:0] mstp_a_i;
	logic pll_locked_o, src_pll_o, cfg_err_o, all_stop_o;
	logic core_system_clock_en_o, flash_interface_clock_en_o;
	logic periph_bus_clock_fast_en_o, periph_bus_clock_slow_en_o;
	logic converter_clock_en_o, timer_count_en_o, timer_bus_en_o;
	int errors, tests_run;
	clock_ratio_and_pll_control dut (.*);
	initial
	begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [17:0] divs();
		return {div_core_o, div_flash_o, div_fast_o, div_slow_o,
			div_timer_o, div_conv_o};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr_div(input logic [17:0] d);
		{div_core_i, div_flash_i, div_fast_i, div_slow_i, div_timer_i,
			div_conv_i} = d;
		cfg_wr_i = 1;
		step(1);
		cfg_wr_i = 0;
		step(1);
	endtask
	task automatic wr_stop(input logic [31:0] w);
		mstp_a_i = w;
		mstp_wr_i = 1;
		step(1);
		mstp_wr_i = 0;
		step(1);
	endtask
	task automatic wr_pll(input logic en, input logic [5:0] k);
		pll_en_i = en;
		pll_multiplier_field_i = k;
		pll_wait_i = 16'h0002;
		pll_wr_i = 1;
		step(1);
		pll_wr_i = 0;
	endtask
	task automatic wr_src(input logic s);
		src_pll_i = s;
		src_wr_i = 1;
		step(1);
		src_wr_i = 0;
		step(1);
	endtask
	task automatic clr_err;
		err_clr_i = 1;
		step(1);
		err_clr_i = 0;
		step(1);
		chk(cfg_err_o, 0);
	endtask
	task automatic t_stop;
		int b[3] = '{24, 27, 29};
		int c;
		foreach (b[i])
		begin
			wr_stop(~(32'h0000_0001 << b[i]));
			chk(all_stop_o, 0);
		end
		wr_stop(32'h2900_0000);
		chk(all_stop_o, 1);
		c = 0;
		repeat (4)
		begin
			step(1);
			c += core_system_clock_en_o;
		end
		chk(c, 0);
		wr_stop(32'h0000_0000);
	endtask
	task automatic t_div;
		logic [17:0] bad[7] = '{18'o721203, 18'o121222, 18'o122203,
			18'o123233, 18'o121205, 18'o121200, 18'o126660};
		int c[7];
		wr_div(18'o062325);
		chk(divs(), 18'o062325);
		wr_div(18'o062322);
		chk({cfg_err_o, divs()}, 18'o062322);
		wr_div(18'o121203);
		foreach (bad[i])
		begin
			wr_div(bad[i]);
			chk({cfg_err_o, divs()}, 19'o1121203);
			clr_err();
		end
		{div_core_i, div_flash_i, div_fast_i, div_slow_i, div_timer_i,
			div_conv_i} = 18'o721203;
		cfg_wr_i = 1;
		err_clr_i = 1;
		step(1);
		cfg_wr_i = 0;
		err_clr_i = 0;
		step(1);
		chk(cfg_err_o, 1);
		clr_err();
		c = '{default: 0};
		repeat (16)
		begin
			step(1);
			c[0] += core_system_clock_en_o;
			c[1] += flash_interface_clock_en_o;
			c[2] += periph_bus_clock_fast_en_o;
			c[3] += periph_bus_clock_slow_en_o;
			c[4] += timer_count_en_o;
			c[5] += converter_clock_en_o;
			c[6] += timer_bus_en_o;
		end
		chk(c[0], 8);
		chk(c[1], 4);
		chk(c[2], 8);
		chk(c[3], 4);
		chk(c[4], 16);
		chk(c[5], 2);
		chk(c[6], 8);
	endtask
	task automatic t_pll;
		int n;
		wr_pll(1, 6'h29);
		step(1);
		chk({cfg_err_o, pll_multiplier_field_o}, 7'h40);
		clr_err();
		wr_src(1);
		chk({cfg_err_o, src_pll_o}, 2'b10);
		clr_err();
		wr_pll(1, 6'h28);
		n = 0;
		while (pll_locked_o !== 1'b1)
		begin
			if (n == 10)
			begin
				errors++;
				wrap_up();
			end
			step(1);
			n++;
		end
		chk(n, 3);
		chk(pll_multiplier_field_o, 6'h28);
		wr_src(1);
		chk({cfg_err_o, src_pll_o}, 2'b01);
		wr_pll(1, 6'h14);
		step(1);
		chk(cfg_err_o, 1);
		wr_src(0);
		clr_err();
		wr_pll(0, 6'h14);
		step(1);
		chk({src_pll_o, pll_locked_o}, 2'b00);
	endtask
	task automatic wrap_up;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		{arst_n_i, cfg_wr_i, pll_wr_i, pll_en_i, src_wr_i} = 0;
		{src_pll_i, mstp_wr_i, err_clr_i, mstp_a_i, pll_wait_i} = 0;
		{div_core_i, div_flash_i, div_fast_i, div_slow_i} = 0;
		{div_timer_i, div_conv_i, pll_multiplier_field_i} = 0;
		errors = 0;
		tests_run = 0;
		step(10);
		arst_n_i = 1;
		step(1);
		chk({all_stop_o, cfg_err_o, src_pll_o, pll_locked_o, divs()},
			22'h20_0000);
		t_stop();
		t_div();
		t_pll();
		wrap_up();
	end
endmodule
`default_nettype wire
